// ---- include/dmaec_pkg.sv ----
/*
 * dmaec_pkg: constants, register map and state types of the channel
 * event capture front end.
 * Assumes one clock domain and a 32-bit AXI4-Lite register port.
 */
package dmaec_pkg;

	// channel array
	localparam int NCH = 64;
	localparam int CH_W = 6;
	localparam int PRIO_W = 3;
	localparam int NSTS = 2;
	localparam int AW = 12;

	// channels that have a hard-wired event source
	localparam logic [63:0] CHAN_WIRED = 64'h00FF_0101_F01E_FFFF;

	// register byte offsets
	localparam logic [11:0] OFF_CAP_LO = 12'h000;
	localparam logic [11:0] OFF_CAP_HI = 12'h004;
	localparam logic [11:0] OFF_EN_LO = 12'h008;
	localparam logic [11:0] OFF_EN_HI = 12'h00C;
	localparam logic [11:0] OFF_IRQ_STS = 12'h010;
	localparam logic [11:0] OFF_IRQ_MSK = 12'h014;
	localparam logic [11:0] OFF_REQ_STS = 12'h018;
	localparam logic [11:0] OFF_PRIO_BASE = 12'h100;
	localparam logic [11:0] OFF_PRIO_MASK = 12'hF00;

	// irq status bit positions
	localparam int STS_MISSED = 0;
	localparam int STS_SERVED = 1;

	// reset values
	localparam logic [63:0] RST_CAP = 64'h0000_0000_0000_0000;
	localparam logic [63:0] RST_EN = 64'h0000_0000_0000_0000;
	localparam logic [1:0] RST_MSK = 2'h0;
	localparam logic [PRIO_W-1:0] RST_PRIO = 3'h0;

	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {RD_IDLE, RD_MEM, RD_LOAD, RD_RESP} dmaec_rd_type;
	typedef enum logic [1:0] {REQ_IDLE, REQ_FETCH, REQ_OFFER} dmaec_req_type;

	typedef struct packed {
		logic [63:0] cap;
		logic [63:0] en;
		logic [1:0] sts;
		logic [1:0] msk;
		logic aw_ok;
		logic [11:0] aw_addr;
		logic w_ok;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		dmaec_rd_type rd;
		logic [11:0] rd_addr;
		logic [31:0] rdata;
		logic [1:0] rresp;
		dmaec_req_type req;
		logic [5:0] req_chan;
	} dmaec_state_type;

endpackage : dmaec_pkg

// ---- core/dmaec_edge.sv ----
/*
 * dmaec_edge: rising-edge detector for a vector of event lines.
 * Assumes the lines come from logic on aclk, so no synchroniser.
 */
`timescale 1ns/1ps
module dmaec_edge #(
	parameter int W = 64
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// events
	input wire logic [W-1:0] level,
	output logic [W-1:0] rise
);

	typedef struct packed {
		logic [W-1:0] prev;
	} dmaec_edge_state_type;

	dmaec_edge_state_type st;
	dmaec_edge_state_type next_st;

	always_comb begin
		next_st = st;
		next_st.prev = level;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign rise = level & ~st.prev;

endmodule : dmaec_edge

// ---- core/dmaec_prio_mem.sv ----
/*
 * dmaec_prio_mem: per-channel priority entries, one write port and two
 * registered read ports.
 * Assumes a single clock; contents are cleared by reset.
 */
`timescale 1ns/1ps
module dmaec_prio_mem (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write port
	input wire logic wr_en,
	input wire logic [5:0] wr_addr,
	input wire logic [2:0] wr_data,
	// read ports
	input wire logic [5:0] rd_a_addr,
	output logic [2:0] rd_a_data,
	input wire logic [5:0] rd_b_addr,
	output logic [2:0] rd_b_data
);

	typedef struct packed {
		logic [63:0][2:0] mem;
		logic [2:0] rda;
		logic [2:0] rdb;
	} dmaec_mem_state_type;

	dmaec_mem_state_type st;
	dmaec_mem_state_type next_st;

	always_comb begin
		next_st = st;
		next_st.rda = st.mem[rd_a_addr];
		next_st.rdb = st.mem[rd_b_addr];
		if (wr_en) begin
			next_st.mem[wr_addr] = wr_data;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= {{64{dmaec_pkg::RST_PRIO}}, 6'h00};
		end else begin
			st <= next_st;
		end
	end

	assign rd_a_data = st.rda;
	assign rd_b_data = st.rdb;

endmodule : dmaec_prio_mem

// ---- core/dmaec_top.sv ----
/*
 * dmaec_top: event routing, capture, enable gating and request issue
 * for a 64-channel transfer controller, with an AXI4-Lite register port.
 * Assumes event inputs come from peripherals on aclk and that the
 * transfer engine accepts requests with a valid/ready handshake.
 */
`timescale 1ns/1ps
module dmaec_top (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// timer-type events
	input wire logic host_irq_event,
	input wire logic timer0_event,
	input wire logic timer1_event,
	input wire logic timer2_event,
	input wire logic wide_mem_refresh_event,
	input wire logic narrow_mem_refresh_event,
	// pin events, bits 4..7 shared with external interrupt pins
	input wire logic [15:0] pin_event,
	// serial port events
	input wire logic serial0_tx_event,
	input wire logic serial0_rx_event,
	input wire logic serial1_tx_event,
	input wire logic serial1_rx_event,
	input wire logic serial2_tx_event,
	input wire logic serial2_rx_event,
	// coprocessor and cell interface events
	input wire logic viterbi_rx_event,
	input wire logic viterbi_tx_event,
	input wire logic turbo_rx_event,
	input wire logic turbo_tx_event,
	input wire logic cell_rx_event,
	input wire logic cell_tx_event,
	// transfer request to the engine
	output logic tr_req_valid,
	input wire logic tr_req_ready,
	output logic [5:0] tr_req_chan,
	output logic [2:0] tr_req_prio,
	// interrupt
	output logic irq,
	// axi4-lite write address
	input wire logic [11:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [11:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// merge a write into a word under byte strobes
	function automatic logic [31:0] apply_strb(
		input logic [31:0] old,
		input logic [31:0] data,
		input logic [3:0] strb
	);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return res;
	endfunction : apply_strb

	// lowest-numbered set bit
	function automatic logic [5:0] first_set(input logic [63:0] v);
		logic [5:0] idx;
		idx = 6'h00;
		for (int i = dmaec_pkg::NCH - 1; i >= 0; i--) begin
			if (v[i]) begin
				idx = 6'(i);
			end
		end
		return idx;
	endfunction : first_set

	// whether an address falls in the priority window
	function automatic logic is_prio(input logic [11:0] a);
		return (a & dmaec_pkg::OFF_PRIO_MASK) == dmaec_pkg::OFF_PRIO_BASE;
	endfunction : is_prio

	dmaec_pkg::dmaec_state_type st;
	dmaec_pkg::dmaec_state_type next_st;

	logic [63:0] ev_level;
	logic [63:0] ev_rise;
	logic [63:0] clr_sw;
	logic [63:0] clr_srv;
	logic [63:0] pending;
	logic [1:0] sts_set;
	logic [1:0] sts_clr;
	logic wr_fire;
	logic mem_wr;
	logic [2:0] mem_rd_data;
	logic [2:0] prio_data;
	logic [31:0] rd_word;

	// fixed event routing; unlisted channels stay low
	always_comb begin
		ev_level = '0;
		ev_level[0] = host_irq_event;
		ev_level[1] = timer0_event;
		ev_level[2] = timer1_event;
		ev_level[3] = wide_mem_refresh_event;
		ev_level[7:4] = pin_event[7:4];
		ev_level[11:8] = pin_event[3:0];
		ev_level[12] = serial0_tx_event;
		ev_level[13] = serial0_rx_event;
		ev_level[14] = serial1_tx_event;
		ev_level[15] = serial1_rx_event;
		ev_level[17] = serial2_tx_event;
		ev_level[18] = serial2_rx_event;
		ev_level[19] = timer2_event;
		ev_level[20] = narrow_mem_refresh_event;
		ev_level[28] = viterbi_rx_event;
		ev_level[29] = viterbi_tx_event;
		ev_level[30] = turbo_rx_event;
		ev_level[31] = turbo_tx_event;
		ev_level[32] = cell_rx_event;
		ev_level[40] = cell_tx_event;
		ev_level[55:48] = pin_event[15:8];
		ev_level = ev_level & dmaec_pkg::CHAN_WIRED;
	end

	// one detector per channel
	dmaec_edge #(
		.W(dmaec_pkg::NCH)
	) u_edge (
		.aclk(aclk),
		.aresetn(aresetn),
		.level(ev_level),
		.rise(ev_rise)
	);

	assign wr_fire = st.aw_ok && st.w_ok && !st.bvalid;
	assign mem_wr = wr_fire && is_prio(st.aw_addr) && st.w_strb[0];

	dmaec_prio_mem u_prio (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr_en(mem_wr),
		.wr_addr(st.aw_addr[7:2]),
		.wr_data(st.w_data[2:0]),
		.rd_a_addr(st.req_chan),
		.rd_a_data(prio_data),
		.rd_b_addr(st.rd_addr[7:2]),
		.rd_b_data(mem_rd_data)
	);

	// register read mux
	always_comb begin
		rd_word = 32'h0000_0000;
		if (is_prio(st.rd_addr)) begin
			rd_word[2:0] = mem_rd_data;
		end else begin
			unique case (st.rd_addr)
				dmaec_pkg::OFF_CAP_LO: rd_word = st.cap[31:0];
				dmaec_pkg::OFF_CAP_HI: rd_word = st.cap[63:32];
				dmaec_pkg::OFF_EN_LO: rd_word = st.en[31:0];
				dmaec_pkg::OFF_EN_HI: rd_word = st.en[63:32];
				dmaec_pkg::OFF_IRQ_STS: rd_word[1:0] = st.sts;
				dmaec_pkg::OFF_IRQ_MSK: rd_word[1:0] = st.msk;
				dmaec_pkg::OFF_REQ_STS: begin
					rd_word[5:0] = st.req_chan;
					rd_word[9:8] = st.req;
				end
				default: rd_word = 32'h0000_0000;
			endcase
		end
	end

	assign pending = st.cap & st.en;

	always_comb begin
		next_st = st;
		clr_sw = '0;
		clr_srv = '0;
		sts_set = '0;
		sts_clr = '0;

		// write address and data taken in either order
		if (s_axi_awvalid && !st.aw_ok) begin
			next_st.aw_ok = 1'b1;
			next_st.aw_addr = {s_axi_awaddr[11:2], 2'b00};
		end
		if (s_axi_wvalid && !st.w_ok) begin
			next_st.w_ok = 1'b1;
			next_st.w_data = s_axi_wdata;
			next_st.w_strb = s_axi_wstrb;
		end
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end
		if (wr_fire) begin
			next_st.aw_ok = 1'b0;
			next_st.w_ok = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = dmaec_pkg::RESP_OKAY;
			if (!is_prio(st.aw_addr)) begin
				unique case (st.aw_addr)
					dmaec_pkg::OFF_CAP_LO: begin
						// write one to clear
						clr_sw[31:0] = apply_strb(32'h0, st.w_data, st.w_strb);
					end
					dmaec_pkg::OFF_CAP_HI: begin
						clr_sw[63:32] = apply_strb(32'h0, st.w_data, st.w_strb);
					end
					dmaec_pkg::OFF_EN_LO: begin
						next_st.en[31:0] = apply_strb(st.en[31:0], st.w_data, st.w_strb);
					end
					dmaec_pkg::OFF_EN_HI: begin
						next_st.en[63:32] = apply_strb(st.en[63:32], st.w_data, st.w_strb);
					end
					dmaec_pkg::OFF_IRQ_MSK: begin
						if (st.w_strb[0]) begin
							next_st.msk = st.w_data[1:0];
						end
					end
					dmaec_pkg::OFF_IRQ_STS, dmaec_pkg::OFF_REQ_STS: begin
						next_st.bresp = dmaec_pkg::RESP_OKAY;
					end
					default: next_st.bresp = dmaec_pkg::RESP_SLVERR;
				endcase
			end
		end

		// read: address, memory cycle, load, answer
		unique case (st.rd)
			dmaec_pkg::RD_IDLE: begin
				if (s_axi_arvalid) begin
					next_st.rd_addr = {s_axi_araddr[11:2], 2'b00};
					next_st.rd = dmaec_pkg::RD_MEM;
				end
			end
			dmaec_pkg::RD_MEM: begin
				next_st.rd = dmaec_pkg::RD_LOAD;
			end
			dmaec_pkg::RD_LOAD: begin
				next_st.rdata = rd_word;
				next_st.rresp = dmaec_pkg::RESP_OKAY;
				if (!is_prio(st.rd_addr)) begin
					unique case (st.rd_addr)
						dmaec_pkg::OFF_CAP_LO, dmaec_pkg::OFF_CAP_HI,
						dmaec_pkg::OFF_EN_LO, dmaec_pkg::OFF_EN_HI,
						dmaec_pkg::OFF_IRQ_MSK, dmaec_pkg::OFF_REQ_STS: begin
							next_st.rresp = dmaec_pkg::RESP_OKAY;
						end
						dmaec_pkg::OFF_IRQ_STS: begin
							// read clears status
							sts_clr = 2'b11;
						end
						default: next_st.rresp = dmaec_pkg::RESP_SLVERR;
					endcase
				end
				next_st.rd = dmaec_pkg::RD_RESP;
			end
			dmaec_pkg::RD_RESP: begin
				if (s_axi_rready) begin
					next_st.rd = dmaec_pkg::RD_IDLE;
				end
			end
		endcase

		// request issue: pick, fetch priority, offer
		unique case (st.req)
			dmaec_pkg::REQ_IDLE: begin
				if (|pending) begin
					next_st.req_chan = first_set(pending);
					next_st.req = dmaec_pkg::REQ_FETCH;
				end
			end
			dmaec_pkg::REQ_FETCH: begin
				// priority entry registered during this cycle
				next_st.req = dmaec_pkg::REQ_OFFER;
			end
			dmaec_pkg::REQ_OFFER: begin
				if (tr_req_ready) begin
					clr_srv[st.req_chan] = 1'b1;
					sts_set[dmaec_pkg::STS_SERVED] = 1'b1;
					next_st.req = dmaec_pkg::REQ_IDLE;
				end
			end
			default: next_st.req = dmaec_pkg::REQ_IDLE;
		endcase

		// capture regardless of enable; a new event beats any clear
		next_st.cap = (st.cap & ~clr_sw & ~clr_srv) | ev_rise;
		sts_set[dmaec_pkg::STS_MISSED] = |(ev_rise & st.cap & ~clr_srv);
		next_st.sts = (st.sts & ~sts_clr) | sts_set;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
			st.cap <= dmaec_pkg::RST_CAP;
			st.en <= dmaec_pkg::RST_EN;
			st.msk <= dmaec_pkg::RST_MSK;
			st.rd <= dmaec_pkg::RD_IDLE;
			st.req <= dmaec_pkg::REQ_IDLE;
		end else begin
			st <= next_st;
		end
	end

	// outputs
	assign tr_req_valid = (st.req == dmaec_pkg::REQ_OFFER);
	assign tr_req_chan = st.req_chan;
	assign tr_req_prio = prio_data;
	assign irq = |(st.sts & st.msk);
	assign s_axi_awready = !st.aw_ok;
	assign s_axi_wready = !st.w_ok;
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp = st.bresp;
	assign s_axi_arready = (st.rd == dmaec_pkg::RD_IDLE);
	assign s_axi_rvalid = (st.rd == dmaec_pkg::RD_RESP);
	assign s_axi_rdata = st.rdata;
	assign s_axi_rresp = st.rresp;

endmodule : dmaec_top

// ---- verif/dmaec_periph_model.sv ----
/*
 * dmaec_periph_model: peripherals that raise one event line per channel.
 * Assumes lines are launched on aclk and stay low between events.
 */
`timescale 1ns/1ps
module dmaec_periph_model (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// control from bench
	input wire logic fire,
	input wire logic [5:0] fire_ch,
	input wire logic [3:0] hold_len,
	// event lines, one per channel
	output logic [63:0] ev
);
	logic [3:0] left;

	// one shared source, one channel high at a time, level held hold_len cycles
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ev <= 64'h0;
			left <= 4'h0;
		end else if (fire) begin
			ev <= 64'h1 << fire_ch;
			left <= hold_len;
		end else if (left > 4'h1) begin
			left <= left - 4'h1;
		end else begin
			ev <= 64'h0;
			left <= 4'h0;
		end
	end
endmodule : dmaec_periph_model

// ---- verif/dmaec_top_chk.sv ----
/*
 * dmaec_top_chk: port checks of request issue and register bus.
 * Assumes bind onto dmaec_top, one clock, synchronous active-low reset.
 */
`timescale 1ns/1ps
module dmaec_top_chk (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// request and interrupt
	input wire logic tr_req_valid,
	input wire logic tr_req_ready,
	input wire logic [5:0] tr_req_chan,
	input wire logic [2:0] tr_req_prio,
	input wire logic irq,
	// bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_req_hold: assert property (
		tr_req_valid && !tr_req_ready |=> tr_req_valid && $stable(tr_req_chan)
		&& $stable(tr_req_prio)) else $error("request changed before accept");
	a_req_wired: assert property (
		tr_req_valid |-> tr_req_chan < 6'h10 && tr_req_chan != 6'h10
		|| tr_req_chan inside {[6'h11:6'h14], [6'h1C:6'h20], 6'h28, [6'h30:6'h37]})
		else $error("request from unconnected channel");
	a_req_gap: assert property (
		tr_req_valid && tr_req_ready |=> !tr_req_valid) else $error("request too soon");
	a_read_lat: assert property (
		s_axi_arvalid && s_axi_arready |=> !s_axi_rvalid [*2] ##1 s_axi_rvalid)
		else $error("read answer late or early");
	a_ar_busy: assert property (
		s_axi_arvalid && s_axi_arready |=> !s_axi_arready) else $error("second read taken");
	a_b_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	a_r_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
		&& $stable(s_axi_rresp)) else $error("read answer dropped");
	a_wr_resp: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer missing");
	a_rst_quiet: assert property (disable iff (1'b0)
		!aresetn |=> !tr_req_valid && !irq && !s_axi_bvalid && !s_axi_rvalid)
		else $error("outputs active after reset");

	c_accept: cover property (tr_req_valid && tr_req_ready);
	c_irq: cover property (irq);
	c_slverr: cover property (s_axi_rvalid && s_axi_rresp == dmaec_pkg::RESP_SLVERR);
endmodule : dmaec_top_chk

bind dmaec_top dmaec_top_chk chk_u (.aclk, .aresetn, .tr_req_valid, .tr_req_ready,
	.tr_req_chan, .tr_req_prio, .irq, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// ---- verif/dma_channel_event_capture_bench.sv ----
/*
 * dma_channel_event_capture_bench: register-level tests of dmaec_top.
 * Assumes dmaec_periph_model and the bound checker are compiled alongside.
 */
`timescale 1ns/1ps
module dma_channel_event_capture_bench;
	// channels with a fixed source
	localparam logic [63:0] WIRED = 64'h00FF_0101_F01E_FFFF;
	logic aclk, aresetn = 1'b0, tr_req_ready = 1'b0, fire = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'hF, hold_len = 4'h1;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic irq, tr_req_valid;
	logic [1:0] s_axi_bresp, s_axi_rresp, r, b;
	logic [5:0] tr_req_chan, fire_ch = 6'h00;
	logic [2:0] tr_req_prio;
	logic [63:0] ev, v;
	int fails = 0, total_checks = 0;

	dmaec_periph_model per_u (.aclk, .aresetn, .fire, .fire_ch, .hold_len, .ev);
	dmaec_top dut_u (.aclk(aclk), .aresetn(aresetn), .tr_req_valid(tr_req_valid),
		.tr_req_ready(tr_req_ready), .tr_req_chan(tr_req_chan), .tr_req_prio(tr_req_prio),
		.irq(irq), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .host_irq_event(ev[0]), .timer0_event(ev[1]),
		.timer1_event(ev[2]),
		.timer2_event(ev[19]), .wide_mem_refresh_event(ev[3]), .narrow_mem_refresh_event(ev[20]),
		.pin_event({ev[55:48], ev[7:4], ev[11:8]}), .serial0_tx_event(ev[12]),
		.serial0_rx_event(ev[13]), .serial1_tx_event(ev[14]), .serial1_rx_event(ev[15]),
		.serial2_tx_event(ev[17]), .serial2_rx_event(ev[18]), .viterbi_rx_event(ev[28]),
		.viterbi_tx_event(ev[29]), .turbo_rx_event(ev[30]), .turbo_tx_event(ev[31]),
		.cell_rx_event(ev[32]), .cell_tx_event(ev[40]));

	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	task automatic summarize();
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : summarize

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [11:0] a, input logic [31:0] dat);
		s_axi_awaddr <= a;
		s_axi_wdata <= dat;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		b = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask : wr

	task automatic rd(input logic [11:0] a, output logic [31:0] dat, output logic [1:0] rsp);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			dat = s_axi_rdata;
			rsp = s_axi_rresp;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask : rd

	task automatic rdcap(output logic [63:0] c);
		logic [31:0] lo, hi;
		logic [1:0] x;
		rd(dmaec_pkg::OFF_CAP_LO, lo, x);
		rd(dmaec_pkg::OFF_CAP_HI, hi, x);
		c = {hi, lo};
	endtask : rdcap

	task automatic pulse(input logic [5:0] c, input logic [3:0] len);
		fire <= 1'b1;
		fire_ch <= c;
		hold_len <= len;
		@(posedge aclk);
		fire <= 1'b0;
		repeat (8) @(posedge aclk);
	endtask : pulse

	initial begin
		repeat (20000) @(posedge aclk);
		fails++;
		summarize();
	end

	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(dmaec_pkg::OFF_EN_LO, d, r);
		chk(d, 64'h0);
		rd(dmaec_pkg::OFF_IRQ_MSK, d, r);
		chk(d, 64'h0);
		rd(12'h020, d, r);
		chk(r, dmaec_pkg::RESP_SLVERR);
		wr(12'h020, 32'h0000_0001);
		chk(b, dmaec_pkg::RESP_SLVERR);
		// every channel alone, enables off, short and long levels
		for (int c = 0; c < 64; c++) begin
			pulse(c[5:0], c[0] ? 4'h3 : 4'h1);
			rdcap(v);
			chk(v, WIRED & (64'h1 << c));
			wr(dmaec_pkg::OFF_CAP_LO, 32'hFFFF_FFFF);
			wr(dmaec_pkg::OFF_CAP_HI, 32'hFFFF_FFFF);
		end
		wr(12'h134, 32'h5);
		chk(b, dmaec_pkg::RESP_OKAY);
		rd(12'h134, d, r);
		chk(d, 64'h5);
		wr(dmaec_pkg::OFF_EN_LO, 32'h0000_2000);
		wr(dmaec_pkg::OFF_IRQ_MSK, 32'h2);
		pulse(6'h0D, 4'h2);
		chk(tr_req_valid, 1'b1);
		chk(tr_req_chan, 6'h0D);
		chk(tr_req_prio, 3'h5);
		rd(dmaec_pkg::OFF_REQ_STS, d, r);
		chk(d, 64'h20D);
		chk(tr_req_valid, 1'b1);
		tr_req_ready <= 1'b1;
		@(posedge aclk);
		tr_req_ready <= 1'b0;
		repeat (2) @(posedge aclk);
		chk(tr_req_valid, 1'b0);
		rdcap(v);
		chk(v, 64'h0);
		chk(irq, 1'b1);
		rd(dmaec_pkg::OFF_IRQ_STS, d, r);
		chk(d, 64'h2);
		chk(irq, 1'b0);
		// disabled channel hit twice: held capture, missed flag
		pulse(6'h05, 4'h1);
		pulse(6'h05, 4'h1);
		rdcap(v);
		chk(v, 64'h20);
		chk(tr_req_valid, 1'b0);
		rd(dmaec_pkg::OFF_IRQ_STS, d, r);
		chk(d, 64'h1);
		// high-word enable: cell transmit channel requests
		wr(dmaec_pkg::OFF_EN_HI, 32'h0000_0100);
		pulse(6'h28, 4'h1);
		chk(tr_req_valid, 1'b1);
		chk(tr_req_chan, 6'h28);
		chk(tr_req_prio, 3'h0);
		tr_req_ready <= 1'b1;
		@(posedge aclk);
		tr_req_ready <= 1'b0;
		repeat (2) @(posedge aclk);
		chk(tr_req_valid, 1'b0);
		summarize();
	end
endmodule : dma_channel_event_capture_bench
